// ==== rtl/acl_link.sv ====
// Decided for this implementation: strobed register access.
`timescale 1ns/1ns
`include "acl_regs.svh"

// Functional notes
// (RL1) Software starts a transaction by writing one to the transmit_go bit.
// (RL2) The device clears transmit_go when the transaction completes, so it reads as busy.
// (RL3) direction_select picks the next transaction: zero receive, one transmit.
// (RL4) In manual mode only software writes direction_select.
// (RL5) With automatic receive set, a receive starts by itself after each transmit.
// (RL6) In automatic receive mode the device writes direction_select to zero after the transmit.
// (RL7) The device sets receive_error_flag when receiving from a mode B antenna fails.
// (RL8) The device clears receive_error_flag at the start of the next transaction of any type.
// (RL9) output_polarity_invert set to one inverts the level driven on the transmit output.
// (RL10) wiring_select zero gives two-pin wiring, one gives one shared two-way pin.
// (RL11) Software sets general_pin_zero as an input before choosing two-pin wiring.
// (RL12) The 14-bit transmit word is split over a low byte and six bits of a high byte.
// (RL13) Software loads the transmit word before setting transmit_go.
// (RL14) The 10-bit received code is kept as a low byte and two bits of a high byte.
// (RL15) In one-pin wiring the pin is driven only while transmitting.

module acl_link #(
   parameter int BIT_CYCLES = `ACL_BIT_CYCLES,
   parameter int TIMEOUT_BITS = `ACL_RX_TIMEOUT_BITS
) (
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   output logic irq_o,
   input wire logic link_i,
   output logic link_o,
   output logic link_oe_o,
   input wire logic link_rx_i
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   acl_pkg::acl_state_t state;
   acl_pkg::acl_state_t next_state;
   logic wiring;
   logic invert;
   logic dir;
   logic go;
   logic auto_rx;
   logic receive_error_flag;
   logic spare;
   logic [7:0] txlo;
   logic [5:0] txhi;
   logic [7:0] rxlo;
   logic [1:0] rxhi;
   logic [2:0] irq_stat;
   logic [2:0] irq_mask;
   logic [3:0] idx;
   logic [7:0] tmo;
   logic [13:0] tx_shift;
   logic [9:0] rx_shift;
   logic [1:0] pins_sync;
   logic mid;
   logic tick;
   logic line_d;

   // ----------------------------------------
   // Pin synchronisers and bit timer
   // ----------------------------------------
   acl_pin_sync #(
      .WIDTH(2)
   ) u_sync (
      .ref_clk_i(ref_clk_i),
      .rst_b_i(rst_b_i),
      .pin_i({link_i, link_rx_i}),
      .sync_o(pins_sync)
   );

   wire restart = (next_state != state);

   acl_bit_timer #(
      .CYCLES(BIT_CYCLES)
   ) u_timer (
      .ref_clk_i(ref_clk_i),
      .rst_b_i(rst_b_i),
      .restart_i(restart),
      .mid_o(mid),
      .tick_o(tick)
   );

   // Receive line: shared pin in one-pin wiring, separate input otherwise.
   wire line = wiring ? pins_sync[1] : pins_sync[0]; // RL10
   // A start needs a rising edge, so the echo of the last sent bit still in the synchroniser is not taken for one.
   wire line_rise = line && !line_d;

   // ----------------------------------------
   // Register decode
   // ----------------------------------------
   wire wr_csr = wr_i && (addr_i == `ACL_ADDR_CSR);
   wire wr_txlo = wr_i && (addr_i == `ACL_ADDR_TXLO);
   wire wr_txhi = wr_i && (addr_i == `ACL_ADDR_TXHI);
   wire wr_rxlo = wr_i && (addr_i == `ACL_ADDR_RXLO);
   wire wr_rxhi = wr_i && (addr_i == `ACL_ADDR_RXHI);
   wire wr_stat = wr_i && (addr_i == `ACL_ADDR_IRQ_STAT);
   wire wr_mask = wr_i && (addr_i == `ACL_ADDR_IRQ_MASK);
   wire busy = (state != acl_pkg::ACL_IDLE) || go;

   wire [7:0] csr_view = {1'b0, spare, receive_error_flag, auto_rx, go, dir, invert, wiring};
   wire [7:0] rd_mux =
      (addr_i == `ACL_ADDR_CSR) ? csr_view :
      (addr_i == `ACL_ADDR_TXLO) ? txlo :
      (addr_i == `ACL_ADDR_TXHI) ? {2'b00, txhi} : // RL12
      (addr_i == `ACL_ADDR_RXLO) ? rxlo :
      (addr_i == `ACL_ADDR_RXHI) ? {6'h00, rxhi} : // RL14
      (addr_i == `ACL_ADDR_IRQ_STAT) ? {5'h00, irq_stat} :
      (addr_i == `ACL_ADDR_IRQ_MASK) ? {5'h00, irq_mask} :
      8'h00;

   // ----------------------------------------
   // Link events
   // ----------------------------------------
   wire tx_done = (state == acl_pkg::ACL_TX) && tick && (idx == 4'hE);
   wire rx_end = (state == acl_pkg::ACL_RX) && mid && (idx == 4'hB);
   wire rx_ok = rx_end && !line;
   wire start_bad = (state == acl_pkg::ACL_RX) && mid && (idx == 4'h0) && !line;
   wire timeout = (state == acl_pkg::ACL_RX_WAIT) && tick && (tmo == 8'(TIMEOUT_BITS - 1));
   wire rx_fail = (rx_end && line) || start_bad || timeout; // RL7
   wire start_txn = ((state == acl_pkg::ACL_IDLE) && go) || (tx_done && auto_rx);
   wire [2:0] events = {rx_fail, rx_ok, tx_done};

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_comb
   begin
      next_state = state;
      case (state)
         acl_pkg::ACL_IDLE:
         begin
            if (go)
               next_state = dir ? acl_pkg::ACL_TX : acl_pkg::ACL_RX_WAIT; // RL3
         end
         acl_pkg::ACL_TX:
         begin
            if (tx_done)
               next_state = auto_rx ? acl_pkg::ACL_RX_WAIT : acl_pkg::ACL_IDLE; // RL5
         end
         acl_pkg::ACL_RX_WAIT:
         begin
            if (timeout)
               next_state = acl_pkg::ACL_IDLE;
            else if (line_rise)
               next_state = acl_pkg::ACL_RX;
         end
         acl_pkg::ACL_RX:
         begin
            if (rx_end || start_bad)
               next_state = acl_pkg::ACL_IDLE;
         end
         default:
            next_state = acl_pkg::ACL_IDLE;
      endcase
   end

   // Bit index: zero is the start bit, then data, then the receive stop bit.
   wire [3:0] next_idx =
      restart ? 4'h0 :
      (((state == acl_pkg::ACL_TX) && tick) || ((state == acl_pkg::ACL_RX) && mid)) ? idx + 4'h1 :
      idx;
   wire [7:0] next_tmo = restart ? 8'h00 : ((state == acl_pkg::ACL_RX_WAIT) && tick) ? tmo + 8'h01 : tmo;

   // Transmit word is loaded as the transmit starts and sent MSB first.
   wire tx_load = (state != acl_pkg::ACL_TX) && (next_state == acl_pkg::ACL_TX);
   wire [13:0] next_tx_shift =
      tx_load ? {txhi, txlo} : // RL12
      ((state == acl_pkg::ACL_TX) && tick && (idx != 4'h0)) ? {tx_shift[12:0], 1'b0} :
      tx_shift;
   wire rx_sample = (state == acl_pkg::ACL_RX) && mid && (idx != 4'h0) && (idx != 4'hB);
   wire [9:0] next_rx_shift = rx_sample ? {rx_shift[8:0], line} : rx_shift;

   // Line level before polarity: start bit high, then data, idle low.
   wire is_tx_next = (next_state == acl_pkg::ACL_TX);
   wire next_link = (is_tx_next && ((next_idx == 4'h0) || next_tx_shift[13])) ^ invert; // RL9
   wire next_oe = wiring ? is_tx_next : 1'b1; // RL15

   // ----------------------------------------
   // Control and status next values
   // ----------------------------------------
   wire next_go =
      (tx_done || rx_end || start_bad || timeout) ? 1'b0 : // RL2
      (wr_csr && !busy) ? wdata_i[`ACL_CSR_GO] : // RL1
      go;
   wire next_dir =
      (tx_done && auto_rx) ? 1'b0 : // RL6
      (wr_csr && !busy) ? wdata_i[`ACL_CSR_DIR] : // RL4
      dir;
   // A failure in the same cycle as a clear leaves the flag set.
   wire next_receive_error_flag =
      rx_fail ? 1'b1 : // RL7
      start_txn ? 1'b0 : // RL8
      wr_csr ? wdata_i[`ACL_CSR_RECEIVE_ERROR_FLAG] :
      receive_error_flag;
   wire [2:0] next_irq_stat = (irq_stat & ~(wr_stat ? wdata_i[2:0] : 3'h0)) | events;

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_b_i)
      begin
         state <= acl_pkg::ACL_IDLE;
         idx <= 4'h0;
         tmo <= 8'h00;
         tx_shift <= 14'h0000;
         rx_shift <= 10'h000;
         link_o <= 1'b0;
         link_oe_o <= 1'b1;
         line_d <= 1'b0;
      end
      else
      begin
         state <= next_state;
         idx <= next_idx;
         tmo <= next_tmo;
         tx_shift <= next_tx_shift;
         rx_shift <= next_rx_shift;
         link_o <= next_link;
         link_oe_o <= next_oe;
         line_d <= line;
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_b_i)
      begin
         {spare, receive_error_flag, auto_rx, go, dir, invert, wiring} <= 7'(`ACL_CSR_RESET);
      end
      else
      begin
         go <= next_go;
         dir <= next_dir;
         receive_error_flag <= next_receive_error_flag;
         if (wr_csr)
         begin
            wiring <= wdata_i[`ACL_CSR_WIRING]; // RL10
            invert <= wdata_i[`ACL_CSR_INVERT];
            auto_rx <= wdata_i[`ACL_CSR_AUTO];
            spare <= wdata_i[`ACL_CSR_SPARE];
         end
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_b_i)
      begin
         txlo <= `ACL_TX_RESET;
         txhi <= 6'(`ACL_TX_RESET);
      end
      else
      begin
         if (wr_txlo)
            txlo <= wdata_i;
         if (wr_txhi)
            txhi <= wdata_i[`ACL_TXHI_BITS-1:0]; // RL12
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_b_i)
      begin
         rxlo <= `ACL_RX_RESET;
         rxhi <= 2'(`ACL_RX_RESET);
      end
      else if (rx_ok)
      begin
         rxlo <= rx_shift[7:0]; // RL14
         rxhi <= rx_shift[9:8];
      end
      else
      begin
         if (wr_rxlo)
            rxlo <= wdata_i;
         if (wr_rxhi)
            rxhi <= wdata_i[`ACL_RXHI_BITS-1:0];
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_b_i)
      begin
         irq_stat <= 3'(`ACL_IRQ_RESET);
         irq_mask <= 3'(`ACL_IRQ_RESET);
         rdata_o <= 8'h00;
      end
      else
      begin
         irq_stat <= next_irq_stat;
         if (wr_mask)
            irq_mask <= wdata_i[2:0];
         if (rd_i)
            rdata_o <= rd_mux;
         else
            rdata_o <= 8'h00;
      end
   end

   assign irq_o = |(irq_stat & irq_mask);

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_go_clears_done: // RL2
      assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
         tx_done |=> !go)
      else $error("transmit_go still set after transmit end");

   a_auto_rx_follows: // RL5
      assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
         (tx_done && auto_rx) |=> (state == acl_pkg::ACL_RX_WAIT) && !dir)
      else $error("automatic receive did not start");

   a_tx_starts_on_go: // RL3
      assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
         ((state == acl_pkg::ACL_IDLE) && go && dir) |=> (state == acl_pkg::ACL_TX) ##1 link_o == !$past(invert))
      else $error("transmit did not begin with a start bit");

   a_receive_error_flag_sets: // RL7
      assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
         rx_fail |=> receive_error_flag && irq_stat[`ACL_IRQ_RECEIVE_ERROR_FLAG])
      else $error("receive failure not flagged");

   a_receive_error_flag_clears: // RL8
      assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
         start_txn |=> !receive_error_flag)
      else $error("receive error not cleared at transaction start");

   a_idle_polarity: // RL9
      assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
         (state == acl_pkg::ACL_IDLE) && (next_state == acl_pkg::ACL_IDLE) |=> link_o == $past(invert))
      else $error("idle level does not follow polarity");

   a_two_pin_drive: // RL10
      assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
         !wiring |=> link_oe_o)
      else $error("two-pin output not driven");

   a_one_pin_release: // RL15
      assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
         (wiring && (state == acl_pkg::ACL_RX_WAIT) && (next_state != acl_pkg::ACL_TX)) |=> !link_oe_o)
      else $error("shared pin driven while receiving");

   a_rx_code_store: // RL14
      assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
         rx_ok |=> {rxhi, rxlo} == $past(rx_shift))
      else $error("received code not stored");

   a_txhi_width: // RL12
      assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
         (wr_txhi && rd_i == 1'b0) |=> (txhi == $past(wdata_i[5:0])))
      else $error("transmit high bits not stored");

endmodule

// ==== rtl/acl_regs.svh ====
`ifndef ACL_REGS_SVH
`define ACL_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ACL_ADDR_CSR 8'h5F
`define ACL_ADDR_TXLO 8'h60
`define ACL_ADDR_TXHI 8'h61
`define ACL_ADDR_RXLO 8'h62
`define ACL_ADDR_RXHI 8'h63
`define ACL_ADDR_IRQ_STAT 8'h64
`define ACL_ADDR_IRQ_MASK 8'h65

// ----------------------------------------
// Control and status fields
// ----------------------------------------
`define ACL_CSR_WIRING 0
`define ACL_CSR_INVERT 1
`define ACL_CSR_DIR 2
`define ACL_CSR_GO 3
`define ACL_CSR_AUTO 4
`define ACL_CSR_RECEIVE_ERROR_FLAG 5
`define ACL_CSR_SPARE 6
`define ACL_TXHI_BITS 6
`define ACL_RXHI_BITS 2

// ----------------------------------------
// Interrupt fields
// ----------------------------------------
`define ACL_IRQ_TXDONE 0
`define ACL_IRQ_RXDONE 1
`define ACL_IRQ_RECEIVE_ERROR_FLAG 2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ACL_CSR_RESET 8'h00
`define ACL_TX_RESET 8'h00
`define ACL_RX_RESET 8'h00
`define ACL_IRQ_RESET 8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define ACL_CLK_PERIOD_NS 10
`define ACL_BIT_TIME_NS 1000
`define ACL_BIT_CYCLES ((`ACL_BIT_TIME_NS + `ACL_CLK_PERIOD_NS - 1) / `ACL_CLK_PERIOD_NS)
`define ACL_RX_TIMEOUT_BITS 32

`endif

// ==== rtl/acl_pkg.sv ====
package acl_pkg;

   typedef enum logic [1:0]
   {
      ACL_IDLE = 2'b00,
      ACL_TX = 2'b01,
      ACL_RX_WAIT = 2'b10,
      ACL_RX = 2'b11
   } acl_state_t;

endpackage

// ==== rtl/acl_pin_sync.sv ====
`timescale 1ns/1ns

module acl_pin_sync #(
   parameter int WIDTH = 2
) (
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic [WIDTH-1:0] pin_i,
   output logic [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] stage1;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1)
      begin : g_bit
         always_ff @(posedge ref_clk_i)
         begin
            if (!rst_b_i)
            begin
               stage1[i] <= 1'b0;
               sync_o[i] <= 1'b0;
            end
            else
            begin
               stage1[i] <= pin_i[i];
               sync_o[i] <= stage1[i];
            end
         end
      end
   endgenerate

endmodule

// ==== rtl/acl_bit_timer.sv ====
`timescale 1ns/1ns

module acl_bit_timer #(
   parameter int CYCLES = 100
) (
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic restart_i,
   output logic mid_o,
   output logic tick_o
);

   logic [15:0] cnt;
   logic [15:0] next_cnt;

   // Tick ends a bit period, mid marks its centre for sampling.
   assign tick_o = (cnt == 16'(CYCLES - 1));
   assign mid_o = (cnt == 16'(CYCLES / 2));
   assign next_cnt = (restart_i || tick_o) ? 16'h0000 : cnt + 16'h0001;

   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_b_i)
         cnt <= 16'h0000;
      else
         cnt <= next_cnt;
   end

endmodule

// ==== testbench/acl_antenna_model.sv ====
`timescale 1ns/1ns

module acl_antenna_model #(
   parameter int BIT_CYCLES = 8
) (
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic line_i,
   input wire logic inv_i,
   input wire logic reply_i,
   input wire logic [9:0] code_i,
   output logic line_o,
   output logic [13:0] word_o,
   output logic got_o
);
   localparam int B = BIT_CYCLES;
   logic [1:0] phase;
   logic prev;
   logic [11:0] frame;
   int cnt;
   wire logic lvl = line_i ^ inv_i;

   // Captures one transmit word, then answers one bit period after its end when asked to.
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_b_i)
      begin
         phase <= 2'd0;
         prev <= 1'b0;
         cnt <= 0;
         line_o <= 1'b0;
         got_o <= 1'b0;
         word_o <= 14'h0000;
         frame <= 12'h000;
      end
      else
      begin
         prev <= lvl;
         cnt <= cnt + 1;
         if (phase == 2'd0 && lvl && !prev)
         begin
            phase <= 2'd1;
            cnt <= 1;
            got_o <= 1'b0;
         end
         if (phase == 2'd1 && cnt > B && cnt % B == B / 2)
            word_o <= {word_o[12:0], lvl};
         if (phase == 2'd1 && cnt == 15 * B)
         begin
            got_o <= 1'b1;
            phase <= reply_i ? 2'd2 : 2'd0;
            cnt <= 0;
            frame <= {1'b1, code_i, 1'b0};
         end
         if (phase == 2'd2 && cnt > 0 && cnt % B == 0)
         begin
            line_o <= frame[11];
            frame <= {frame[10:0], 1'b0};
         end
         if (phase == 2'd2 && cnt == 13 * B)
         begin
            phase <= 2'd0;
            line_o <= 1'b0;
         end
      end
   end
endmodule

// ==== testbench/antenna_control_link_tb_top.sv ====
`timescale 1ns/1ns
`include "acl_regs.svh"

module antenna_control_link_tb_top;
   localparam int BC = 8;
   logic ref_clk_i = 0, rst_b_i = 0, wr_i = 0, rd_i = 0;
   logic ant_rst_b = 0, ant_inv = 0, ant_reply = 0, one_pin = 0;
   logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rd_val;
   logic [9:0] ant_code = 10'h000;
   logic [7:0] rdata_o;
   logic irq_o, link_o, link_oe_o, ant_line, ant_got;
   logic [13:0] ant_word;
   int n_errors = 0, checked = 0;
   wire logic link_i = link_oe_o ? link_o : ant_line;
   wire logic link_rx_i = one_pin ? 1'b0 : ant_line;

   always #5 ref_clk_i = ~ref_clk_i;

   acl_link #(.BIT_CYCLES(BC), .TIMEOUT_BITS(4)) i_dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
      .link_i(link_i), .link_o(link_o), .link_oe_o(link_oe_o), .link_rx_i(link_rx_i));

   acl_antenna_model #(.BIT_CYCLES(BC)) i_ant (.ref_clk_i(ref_clk_i), .rst_b_i(ant_rst_b), .line_i(link_i),
      .inv_i(ant_inv), .reply_i(ant_reply), .code_i(ant_code), .line_o(ant_line), .word_o(ant_word),
      .got_o(ant_got));

   // ----------------------------------------
   // Bus and check helpers
   // ----------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [7:0] a);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      #1;
      rd_val = rdata_o;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      rd(a);
      check({8'h00, rd_val}, {8'h00, e});
   endtask

   task automatic wait_idle();
      for (int i = 0; i < 400; i++)
      begin
         rd(`ACL_ADDR_CSR);
         if (rd_val[`ACL_CSR_GO] === 1'b0)
            break;
      end
      check({15'h0000, rd_val[`ACL_CSR_GO]}, 16'h0000);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs();
      check({15'h0000, link_oe_o}, 16'h0001);
      for (int a = 'h5F; a <= 'h65; a++)
         rd_chk(a[7:0], 8'h00);
      rd_chk(8'h70, 8'h00);
      wr(`ACL_ADDR_TXHI, 8'hFF);
      rd_chk(`ACL_ADDR_TXHI, 8'h3F);
      wr(`ACL_ADDR_TXLO, 8'hA5);
      rd_chk(`ACL_ADDR_TXLO, 8'hA5);
      wr(`ACL_ADDR_RXLO, 8'h5A);
      rd_chk(`ACL_ADDR_RXLO, 8'h5A);
      wr(`ACL_ADDR_RXHI, 8'hFF);
      rd_chk(`ACL_ADDR_RXHI, 8'h03);
      wr(`ACL_ADDR_CSR, 8'hC0);
      rd_chk(`ACL_ADDR_CSR, 8'h40);
      wr(`ACL_ADDR_CSR, 8'h00);
      $display("test regs done");
   endtask

   task automatic t_tx(input logic [13:0] w, input logic inv, input logic pin);
      ant_rst_b <= 1'b0;
      ant_reply <= 1'b0;
      one_pin <= pin;
      ant_inv <= inv;
      wr(`ACL_ADDR_CSR, {6'h00, inv, pin});
      wr(`ACL_ADDR_TXLO, w[7:0]);
      wr(`ACL_ADDR_TXHI, {2'b00, w[13:8]});
      idle(3);
      if (!pin)
         check({15'h0000, link_o}, {15'h0000, inv});
      ant_rst_b <= 1'b1;
      idle(2);
      wr(`ACL_ADDR_CSR, {4'h0, 2'b11, inv, pin});
      rd(`ACL_ADDR_CSR);
      check({15'h0000, rd_val[`ACL_CSR_GO]}, 16'h0001);
      if (pin)
         check({15'h0000, link_oe_o}, 16'h0001);
      wait_idle();
      check({2'b00, ant_word}, {2'b00, w});
      check({15'h0000, ant_got}, 16'h0001);
      rd_chk(`ACL_ADDR_IRQ_STAT, 8'h01);
      wr(`ACL_ADDR_IRQ_STAT, 8'h01);
      rd_chk(`ACL_ADDR_IRQ_STAT, 8'h00);
      $display("test tx done");
   endtask

   task automatic t_auto(input logic [9:0] code);
      ant_rst_b <= 1'b0;
      ant_reply <= 1'b1;
      ant_code <= code;
      one_pin <= 1'b1;
      ant_inv <= 1'b0;
      wr(`ACL_ADDR_CSR, 8'h01);
      wr(`ACL_ADDR_IRQ_MASK, 8'h02);
      wr(`ACL_ADDR_TXLO, 8'h33);
      wr(`ACL_ADDR_TXHI, 8'h0C);
      ant_rst_b <= 1'b1;
      idle(2);
      wr(`ACL_ADDR_CSR, 8'h1D);
      wait_idle();
      check({15'h0000, rd_val[`ACL_CSR_DIR]}, 16'h0000);
      check({15'h0000, link_oe_o}, 16'h0000);
      check({15'h0000, irq_o}, 16'h0000);
      for (int i = 0; i < 300 && irq_o !== 1'b1; i++)
         idle(1);
      check({15'h0000, irq_o}, 16'h0001);
      check({2'b00, ant_word}, 16'h0C33);
      rd_chk(`ACL_ADDR_RXLO, code[7:0]);
      rd_chk(`ACL_ADDR_RXHI, {6'h00, code[9:8]});
      rd_chk(`ACL_ADDR_IRQ_STAT, 8'h03);
      wr(`ACL_ADDR_IRQ_STAT, 8'h02);
      idle(1);
      check({15'h0000, irq_o}, 16'h0000);
      rd_chk(`ACL_ADDR_CSR, 8'h11);
      wr(`ACL_ADDR_IRQ_STAT, 8'h07);
      $display("test auto receive done");
   endtask

   task automatic t_err();
      ant_rst_b <= 1'b0;
      ant_reply <= 1'b0;
      one_pin <= 1'b0;
      wr(`ACL_ADDR_IRQ_MASK, 8'h04);
      ant_rst_b <= 1'b1;
      wr(`ACL_ADDR_CSR, 8'h08);
      wait_idle();
      check({15'h0000, rd_val[`ACL_CSR_RECEIVE_ERROR_FLAG]}, 16'h0001);
      check({15'h0000, ant_got}, 16'h0000);
      check({15'h0000, irq_o}, 16'h0001);
      wr(`ACL_ADDR_IRQ_STAT, 8'h04);
      wr(`ACL_ADDR_CSR, 8'h2C);
      idle(2);
      rd(`ACL_ADDR_CSR);
      check({15'h0000, rd_val[`ACL_CSR_RECEIVE_ERROR_FLAG]}, 16'h0000);
      wait_idle();
      check({2'b00, ant_word}, 16'h0C33);
      $display("test receive error done");
   endtask

   // ----------------------------------------
   // Sequence and verdict
   // ----------------------------------------
   task automatic stop_test();
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial
   begin
      idle(2);
      rst_b_i <= 1'b1;
      idle(1);
      t_regs();
      t_tx(14'h2A5C, 1'b0, 1'b0);
      t_tx(14'h15A3, 1'b1, 1'b0);
      t_tx(14'h2001, 1'b0, 1'b1);
      t_auto(10'h2B7);
      t_err();
      stop_test();
   end

   initial
   begin
      #100000;
      n_errors++;
      $display("BAD %0t watchdog expired", $time);
      stop_test();
   end
endmodule
